// ---- omec_chk_properties.sv ----
// checker: run/pause, break and routing properties of the control block
`timescale 1ns/100ps
module omec_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_ready,
    input wire logic ovl_sel,
    input wire logic tgt_sel,
    input wire logic brk_req,
    input wire logic mon_stop,
    input wire logic target_err,
    input wire logic run_o,
    input wire logic fsi_o,
    input wire logic intclk_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // break causes sampled while running
    property p_terr; run_o && !brk_req && target_err |=> brk_req; endproperty
    a_terr: assert property (p_terr) else $error("no break on target error");
    property p_mon; run_o && !brk_req && mon_stop |=> brk_req; endproperty
    a_mon: assert property (p_mon) else $error("no break on monitor stop");
    // break leaves run for pause, one pulse
    property p_pause; brk_req |=> !run_o; endproperty
    a_pause: assert property (p_pause) else $error("still running after break");
    property p_brk; brk_req |-> run_o ##1 !brk_req; endproperty
    a_brk: assert property (p_brk) else $error("break pulse outside run");
    // routing, ready pulse and special interrupt pulse
    property p_excl; !(ovl_sel && tgt_sel); endproperty
    a_excl: assert property (p_excl) else $error("overlay and target both selected");
    property p_tgt; $rose(tgt_sel) |-> ##[0:1] cpu_ready; endproperty
    a_tgt: assert property (p_tgt) else $error("target access delayed");
    property p_nul; intclk_o |-> !tgt_sel; endproperty
    a_nul: assert property (p_nul) else $error("target used in null mode");
    property p_rdy; cpu_ready |=> !cpu_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready longer than a cycle");
    property p_fsi; fsi_o |-> run_o ##1 !fsi_o; endproperty
    a_fsi: assert property (p_fsi) else $error("bad special interrupt pulse");
endmodule
bind omec_ctrl omec_chk u_chk (.clk(clk), .rst(rst), .cpu_ready(cpu_ready),
    .ovl_sel(ovl_sel), .tgt_sel(tgt_sel), .brk_req(brk_req), .mon_stop(mon_stop),
    .target_err(target_err), .run_o(run_o), .fsi_o(fsi_o), .intclk_o(intclk_o));

// ---- omec_cpu_model.sv ----
// processor bus model: one access at a time, lines released between
`timescale 1ns/100ps
module omec_cpu_model #(parameter int ADDR_W = 20) (
    input wire logic clk,
    input wire logic cpu_ready,
    input wire logic ovl_sel,
    input wire logic tgt_sel,
    input wire logic [ADDR_W-1:0] ovl_addr,
    output logic cpu_req = 1'h0,
    output logic [ADDR_W-1:0] cpu_addr = '0,
    output logic cpu_we = 1'h0
);
    // request held until ready, then low for a cycle
    task access(input logic [ADDR_W-1:0] a, input logic w, output int lat, output logic o,
        output logic t, output logic [ADDR_W-1:0] oa);
        lat = 0;
        o = 1'h0;
        t = 1'h0;
        oa = '0;
        cpu_req <= 1'h1;
        cpu_addr <= a;
        cpu_we <= w;
        do
        begin
            @(posedge clk);
            lat++;
            o = o | ovl_sel;
            t = t | tgt_sel;
            if (ovl_sel === 1'h1) oa = ovl_addr;
        end while (cpu_ready !== 1'h1);
        cpu_req <= 1'h0;
        cpu_addr <= ~a; // no stale address after release
        cpu_we <= ~w;
        @(posedge clk);
    endtask
endmodule

// ---- omec_ctrl.sv ----
// overlay map emulation control: run/pause, segment map, access routing
`timescale 1ns/100ps
// Function
// - two states only: running emulation and paused
// - run ends on stop, breakpoint, emulator reset or target error
// - stop or breakpoint puts controller into pause
// - target accesses in run get no added wait states
// - address space split into 2kb segments, one map entry each
// - each entry holds target, read/write, read-only or illegal
// - overlay-mapped accesses go to overlay ram, never to target
// - programmable 0 to 15 overlay wait states, zero allowed
// - overlay accesses real time apart from programmed waits
// - overlay size selectable 128k to 2m, mapping honours it
// - overlay access or write violation breaks emulation automatically
// - event monitor stop request breaks emulation
// - command forces special interrupt into running processor
// - internal clock select gives null target mode
module omec_ctrl #(
    parameter int ADDR_W = 20,
    parameter int SEGS = 512
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic cpu_req,
    input wire logic cpu_we,
    output logic cpu_ready,
    output logic ovl_sel,
    output logic [ADDR_W-1:0] ovl_addr,
    output logic tgt_sel,
    output logic brk_req,
    input wire logic mon_stop,
    input wire logic target_err,
    output logic run_o,
    output logic fsi_o,
    output logic intclk_o
);
    localparam int SEG_IDX_W = ADDR_W - omec_pkg::OMEC_SEG_BITS;

    omec_pkg::omec_state_e state_r;
    logic [1:0] map_r [SEGS];
    logic [3:0] wait_r;
    logic intclk_r;
    logic [2:0] size_r;
    logic [2:0] cause_r;
    logic [3:0] wcnt_r;
    logic busy_r;
    logic aw_got_r, w_got_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r; // strobes held with the captured data word

    // axi write channel capture, either order
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    wire sel_ctrl = awaddr_r == omec_pkg::OMEC_CTRL_OFF;
    wire sel_cmd = awaddr_r == omec_pkg::OMEC_CMD_OFF;
    wire sel_map = awaddr_r == omec_pkg::OMEC_MAP_OFF;
    wire sel_stat = awaddr_r == omec_pkg::OMEC_STAT_OFF;
    wire wr_ok = sel_ctrl || sel_cmd || sel_map || sel_stat;
    wire cmd_wr = wr_go && sel_cmd && wstrb_r[0];
    wire cmd_run = cmd_wr && wdata_r[omec_pkg::OMEC_CMD_RUN];
    wire cmd_stop = cmd_wr && wdata_r[omec_pkg::OMEC_CMD_STOP];
    wire cmd_reset = cmd_wr && wdata_r[omec_pkg::OMEC_CMD_RESET];
    wire cmd_fsi = cmd_wr && wdata_r[omec_pkg::OMEC_CMD_FSI];
    wire map_wr = wr_go && sel_map && wdata_r[omec_pkg::OMEC_MAP_WE];
    wire [SEG_IDX_W-1:0] map_widx = wdata_r[SEG_IDX_W-1:0];
    wire [1:0] map_wattr = wdata_r[omec_pkg::OMEC_MAP_ATTR_LSB +: 2];

    // segment lookup of current processor access
    wire [SEG_IDX_W-1:0] seg = cpu_addr[ADDR_W-1:omec_pkg::OMEC_SEG_BITS];
    wire [1:0] attr = map_r[seg];
    wire is_ovl = attr == omec_pkg::OMEC_ATTR_RW || attr == omec_pkg::OMEC_ATTR_RO;
    wire viol = (attr == omec_pkg::OMEC_ATTR_ILLEGAL)
        || (attr == omec_pkg::OMEC_ATTR_RO && cpu_we);
    // overlay address wraps within the chosen board size
    wire [4:0] ovl_bits = 5'(omec_pkg::OMEC_OVL_BASE_BITS) + {2'h0, size_r};
    wire [ADDR_W-1:0] ovl_mask = ADDR_W'((33'h1 << ovl_bits) - 33'h1);
    wire running = state_r == omec_pkg::OMEC_RUN;
    wire acc_new = cpu_req && !busy_r && !cpu_ready;
    wire viol_hit = running && acc_new && viol;

    // break cause priority: reset, target error, violation, stop, monitor
    wire brk_any = running && (cmd_reset || target_err || viol_hit || cmd_stop || mon_stop);
    wire [2:0] cause_nxt = cmd_reset ? omec_pkg::OMEC_CAUSE_RESET :
        target_err ? omec_pkg::OMEC_CAUSE_TERR :
        viol_hit ? omec_pkg::OMEC_CAUSE_VIOL :
        cmd_stop ? omec_pkg::OMEC_CAUSE_STOP : omec_pkg::OMEC_CAUSE_MON;

    // read data mux
    wire [31:0] rd_val =
        s_axi_araddr == omec_pkg::OMEC_CTRL_OFF ? {21'h0, size_r, 3'h0, intclk_r, wait_r} :
        s_axi_araddr == omec_pkg::OMEC_STAT_OFF ? {28'h0, cause_r, running} :
        32'h0;
    wire rd_ok = s_axi_araddr == omec_pkg::OMEC_CTRL_OFF
        || s_axi_araddr == omec_pkg::OMEC_STAT_OFF
        || s_axi_araddr == omec_pkg::OMEC_CMD_OFF
        || s_axi_araddr == omec_pkg::OMEC_MAP_OFF;

    // axi handshake state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= omec_pkg::OMEC_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_hs)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb; // master may drop strobes once data is taken
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? omec_pkg::OMEC_RESP_OKAY : omec_pkg::OMEC_RESP_SLVERR;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // axi read: one cycle answer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= omec_pkg::OMEC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? omec_pkg::OMEC_RESP_OKAY : omec_pkg::OMEC_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // configuration register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_r <= 4'h0;
            intclk_r <= 1'b0;
            size_r <= 3'h0;
        end
        else if (wr_go && sel_ctrl)
        begin
            if (wstrb_r[0])
            begin
                wait_r <= wdata_r[omec_pkg::OMEC_CTRL_WAIT_LSB +: omec_pkg::OMEC_CTRL_WAIT_W];
                intclk_r <= wdata_r[omec_pkg::OMEC_CTRL_INTCLK];
            end
            if (wstrb_r[1] &&
                wdata_r[omec_pkg::OMEC_CTRL_SIZE_LSB +: omec_pkg::OMEC_CTRL_SIZE_W]
                    <= omec_pkg::OMEC_SIZE_MAX)
                size_r <= wdata_r[omec_pkg::OMEC_CTRL_SIZE_LSB +: omec_pkg::OMEC_CTRL_SIZE_W];
        end
    end

    // segment map memory, cleared to target at reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < SEGS; i++)
                map_r[i] <= omec_pkg::OMEC_ATTR_TARGET;
        else if (map_wr)
            map_r[map_widx] <= map_wattr;
    end

    // run/pause state machine
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= omec_pkg::OMEC_PAUSE;
            cause_r <= omec_pkg::OMEC_CAUSE_NONE;
            brk_req <= 1'b0;
            fsi_o <= 1'b0;
        end
        else
        begin
            brk_req <= 1'b0;
            fsi_o <= running && cmd_fsi && !brk_any;
            case (state_r)
                omec_pkg::OMEC_PAUSE:
                begin
                    if (cmd_run && !cmd_stop && !cmd_reset)
                    begin
                        state_r <= omec_pkg::OMEC_RUN;
                        cause_r <= omec_pkg::OMEC_CAUSE_NONE;
                    end
                end
                omec_pkg::OMEC_RUN:
                begin
                    if (brk_any)
                    begin
                        state_r <= omec_pkg::OMEC_PAUSE;
                        cause_r <= cause_nxt;
                        brk_req <= 1'b1;
                    end
                end
                default:
                    state_r <= omec_pkg::OMEC_PAUSE;
            endcase
        end
    end

    // access routing and wait insertion
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            wcnt_r <= 4'h0;
            cpu_ready <= 1'b0;
            ovl_sel <= 1'b0;
            tgt_sel <= 1'b0;
            ovl_addr <= '0;
        end
        else
        begin
            cpu_ready <= 1'b0;
            if (acc_new)
            begin
                ovl_sel <= is_ovl && !viol;
                tgt_sel <= (attr == omec_pkg::OMEC_ATTR_TARGET) && !intclk_r;
                ovl_addr <= cpu_addr & ovl_mask;
                if (is_ovl && !viol && wait_r != 4'h0)
                begin
                    busy_r <= 1'b1;
                    wcnt_r <= wait_r;
                end
                else
                    cpu_ready <= 1'b1;
            end
            else if (busy_r)
            begin
                wcnt_r <= wcnt_r - 4'h1;
                if (wcnt_r == 4'h1)
                begin
                    busy_r <= 1'b0;
                    cpu_ready <= 1'b1;
                end
            end
            else if (!cpu_req)
            begin
                ovl_sel <= 1'b0;
                tgt_sel <= 1'b0;
            end
        end
    end

    // status pins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run_o <= 1'b0;
            intclk_o <= 1'b0;
        end
        else
        begin
            run_o <= running;
            intclk_o <= intclk_r;
        end
    end
endmodule

// ---- omec_pkg.sv ----
// package: register map, attribute codes and sizes for the overlay map emulation control
package omec_pkg;
    // axi register byte offsets
    localparam logic [11:0] OMEC_CTRL_OFF = 12'h000;
    localparam logic [11:0] OMEC_CMD_OFF = 12'h004;
    localparam logic [11:0] OMEC_STAT_OFF = 12'h008;
    localparam logic [11:0] OMEC_MAP_OFF = 12'h00c;
    // ctrl field positions
    localparam int OMEC_CTRL_WAIT_LSB = 0;
    localparam int OMEC_CTRL_WAIT_W = 4;
    localparam int OMEC_CTRL_INTCLK = 4;
    localparam int OMEC_CTRL_SIZE_LSB = 8;
    localparam int OMEC_CTRL_SIZE_W = 3;
    // cmd bits
    localparam int OMEC_CMD_RUN = 0;
    localparam int OMEC_CMD_STOP = 1;
    localparam int OMEC_CMD_RESET = 2;
    localparam int OMEC_CMD_FSI = 3;
    // map register: index in [15:0], attribute in [17:16], write strobe bit 31
    localparam int OMEC_MAP_IDX_W = 16;
    localparam int OMEC_MAP_ATTR_LSB = 16;
    localparam int OMEC_MAP_WE = 31;
    // status bits
    localparam int OMEC_ST_RUN = 0;
    localparam int OMEC_ST_CAUSE_LSB = 1;
    localparam int OMEC_ST_CAUSE_W = 3;
    // segment size 2kb
    localparam int OMEC_SEG_BITS = 11;
    // overlay size codes 0..4 = 128k..2m; log2 bytes of 128k
    localparam int OMEC_OVL_BASE_BITS = 17;
    localparam logic [2:0] OMEC_SIZE_MAX = 3'h4;
    // segment attributes
    localparam logic [1:0] OMEC_ATTR_TARGET = 2'h0;
    localparam logic [1:0] OMEC_ATTR_RW = 2'h1;
    localparam logic [1:0] OMEC_ATTR_RO = 2'h2;
    localparam logic [1:0] OMEC_ATTR_ILLEGAL = 2'h3;
    // break causes
    localparam logic [2:0] OMEC_CAUSE_NONE = 3'h0;
    localparam logic [2:0] OMEC_CAUSE_STOP = 3'h1;
    localparam logic [2:0] OMEC_CAUSE_BRK = 3'h2;
    localparam logic [2:0] OMEC_CAUSE_RESET = 3'h3;
    localparam logic [2:0] OMEC_CAUSE_TERR = 3'h4;
    localparam logic [2:0] OMEC_CAUSE_VIOL = 3'h5;
    localparam logic [2:0] OMEC_CAUSE_MON = 3'h6;
    localparam logic [1:0] OMEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] OMEC_RESP_SLVERR = 2'h2;
    // run/pause states
    typedef enum logic {OMEC_PAUSE, OMEC_RUN} omec_state_e;
endpackage

// ---- testbench.sv ----
// testbench: registers, routing, wait states, sizes and break causes
`timescale 1ns/100ps
module testbench;
    logic clk = 1'h0, rst = 1'h1, mon_stop = 1'h0, target_err = 1'h0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, cpu_req, cpu_we, cpu_ready;
    logic ovl_sel, tgt_sel, brk_req, run_o, fsi_o, intclk_o;
    logic [1:0] bresp, rresp;
    logic [19:0] cpu_addr, ovl_addr;
    int num_errors = 0, check_count = 0, cyc = 0, brk_n = 0, fsi_n = 0;
    int attr[512];
    always #2.5 clk = ~clk;
    omec_ctrl uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_addr(cpu_addr), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_ready(cpu_ready),
        .ovl_sel(ovl_sel), .ovl_addr(ovl_addr), .tgt_sel(tgt_sel), .brk_req(brk_req),
        .mon_stop(mon_stop), .target_err(target_err), .run_o(run_o), .fsi_o(fsi_o),
        .intclk_o(intclk_o));
    omec_cpu_model cpu (.clk(clk), .cpu_ready(cpu_ready), .ovl_sel(ovl_sel),
        .tgt_sel(tgt_sel), .ovl_addr(ovl_addr), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
        .cpu_we(cpu_we));
    // pulse counters and run limit
    always @(posedge clk)
    begin
        cyc++;
        if (brk_req === 1'h1) brk_n++;
        if (fsi_o === 1'h1) fsi_n++;
        if (cyc > 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // axi write: address and data offered together, released as taken
    task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready)
            begin
                wvalid <= 1'h0;
                wstrb <= 4'h0; // strobes released with the data
            end
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask
    task end_sim();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        int lat, we, k, w, sz;
        int seg[4];
        logic o, t, v;
        logic [19:0] a, oa;
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] cz[4];
        cz = '{omec_pkg::OMEC_CAUSE_STOP, omec_pkg::OMEC_CAUSE_RESET,
            omec_pkg::OMEC_CAUSE_TERR, omec_pkg::OMEC_CAUSE_MON};
        void'($urandom(58));
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rd(omec_pkg::OMEC_STAT_OFF, d, r);
        chk(d, 32'h0);
        chk(r, omec_pkg::OMEC_RESP_OKAY);
        rd(omec_pkg::OMEC_CTRL_OFF, d, r);
        chk(d, 32'h0);
        // unmapped offset refused on both directions
        rd(12'h010, d, r);
        chk(r, omec_pkg::OMEC_RESP_SLVERR);
        chk(d, 32'h0);
        wr(12'h010, 32'h0, r);
        chk(r, omec_pkg::OMEC_RESP_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            seg[i] = i * 64 + $urandom % 64;
            attr[seg[i]] = i;
            wr(omec_pkg::OMEC_MAP_OFF, {1'h1, 13'h0, i[1:0], 7'h0, seg[i][8:0]}, r);
            chk(r, omec_pkg::OMEC_RESP_OKAY);
        end
        // each attribute from run, read-only segment written and read
        for (int i = 0; i < 5; i++)
        begin
            k = (i == 4) ? 2 : i;
            we = (i == 2) ? 1 : (i == 4) ? 0 : $urandom % 2;
            wr(omec_pkg::OMEC_CMD_OFF, 32'h1, r);
            a = {seg[k][8:0], 11'($urandom)};
            cpu.access(a, we[0], lat, o, t, oa);
            chk(lat, 2);
            v = (attr[seg[k]] == 3) || (attr[seg[k]] == 2 && we == 1);
            chk(o, !v && attr[seg[k]] != 0);
            chk(t, attr[seg[k]] == 0);
            if (o === 1'h1) chk(oa, a & 20'h1ffff);
            rd(omec_pkg::OMEC_STAT_OFF, d, r);
            chk(d[3:0], v ? {omec_pkg::OMEC_CAUSE_VIOL, 1'h0} : 4'h1);
        end
        // wait states none, most and random, overlay size random
        for (int j = 0; j < 3; j++)
        begin
            w = (j == 0) ? 0 : (j == 1) ? 15 : $urandom % 16;
            sz = $urandom % 5;
            wr(omec_pkg::OMEC_CTRL_OFF, (sz << 8) | w, r);
            rd(omec_pkg::OMEC_CTRL_OFF, d, r);
            chk(d, (sz << 8) | w);
            a = {seg[1][8:0], 11'($urandom)};
            cpu.access(a, 1'h1, lat, o, t, oa);
            chk(lat, 2 + w);
            chk(oa, a & ((20'h1 << (17 + sz)) - 1));
        end
        // size codes above the largest board leave the size alone
        wr(omec_pkg::OMEC_CTRL_OFF, 32'h700, r);
        rd(omec_pkg::OMEC_CTRL_OFF, d, r);
        chk(d, sz << 8);
        // null target mode
        wr(omec_pkg::OMEC_CTRL_OFF, 32'h10, r);
        chk(intclk_o, 1'h1);
        cpu.access({seg[0][8:0], 11'h0}, 1'h0, lat, o, t, oa);
        chk(t, 1'h0);
        wr(omec_pkg::OMEC_CTRL_OFF, 32'h0, r);
        wr(omec_pkg::OMEC_CMD_OFF, 32'h8, r);
        chk(fsi_n, 1);
        // stop, reset, target error and monitor causes from run
        for (int c = 0; c < 4; c++)
        begin
            wr(omec_pkg::OMEC_CMD_OFF, 32'h1, r);
            if (c < 2) wr(omec_pkg::OMEC_CMD_OFF, (c == 0) ? 32'h2 : 32'h4, r);
            else
            begin
                if (c == 2) target_err <= 1'h1;
                else mon_stop <= 1'h1;
                @(posedge clk);
                target_err <= 1'h0;
                mon_stop <= 1'h0;
            end
            repeat (3) @(posedge clk);
            rd(omec_pkg::OMEC_STAT_OFF, d, r);
            chk(d[3:0], {cz[c], 1'h0});
        end
        chk(brk_n, 6);
        end_sim();
    end
endmodule
